// ### core/gpn_pkg.sv
package gpn_pkg;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] P9_DATA_OFS   = 8'h00;
    localparam logic [7:0] P9_DIR_OFS    = 8'h04;
    localparam logic [7:0] P9_ALT_OFS    = 8'h08;
    localparam logic [7:0] P10_DATA_OFS  = 8'h0c;
    localparam logic [7:0] P10_DIR_OFS   = 8'h10;
    localparam logic [7:0] P10_ALT_OFS   = 8'h14;
    localparam logic [7:0] P11_DATA_OFS  = 8'h18;
    localparam logic [7:0] P11_DIR_OFS   = 8'h1c;
    localparam logic [7:0] P11_ALT_OFS   = 8'h20;

    // ----------------------------------------------------------------
    // implemented bits, constant-zero outputs, reset value
    // ----------------------------------------------------------------
    localparam logic [7:0] P9_IMPL       = 8'h8f;
    localparam logic [7:0] P10_IMPL      = 8'h38;
    localparam logic [7:0] P11_IMPL      = 8'h0f;
    localparam logic [7:0] P9_ZERO_ALT   = 8'h0f;
    localparam logic [7:0] P10_ZERO_ALT  = 8'h20;
    localparam logic [7:0] P11_ZERO_ALT  = 8'h03;
    localparam logic [7:0] REG_RESET     = 8'h00;

    localparam int         NUM_PORTS     = 3;

    typedef enum logic [1:0] {
        GPN_PORT9  = 2'b00,
        GPN_PORT10 = 2'b01,
        GPN_PORT11 = 2'b10
    } gpn_port_t;

endpackage

// ### core/gpn_bank_if.sv
`timescale 1ns/1ps
`default_nettype none

interface gpn_bank_if;
    logic       wrEn;
    logic [1:0] sel;
    logic [7:0] wData;
    logic [7:0] dataOut;
    logic [7:0] dirOut;
    logic [7:0] altOut;

    modport bank (
        input  wrEn, sel, wData,
        output dataOut, dirOut, altOut
    );
    modport ctrl (
        output wrEn, sel, wData,
        input  dataOut, dirOut, altOut
    );
endinterface

`default_nettype wire

// ### core/gpn_port_bank.sv
`timescale 1ns/1ps
`default_nettype none

// one port: data, direction and alternate-select registers
module gpn_port_bank
    import gpn_pkg::*;
#(
    parameter logic [7:0] IMPL = 8'hff
) (
    // clock and reset
    input  wire logic   mclk,
    input  wire logic   rst_b,
    // register access
    gpn_bank_if.bank    bus
);

    logic [7:0] dataFf;
    logic [7:0] dirFf;
    logic [7:0] altFf;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // all clear on reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dataFf <= REG_RESET;
            dirFf  <= REG_RESET;
            altFf  <= REG_RESET;
        end else if (bus.wrEn) begin
            unique case (bus.sel)
                2'd0:    dataFf <= bus.wData & IMPL;
                2'd1:    dirFf  <= bus.wData & IMPL;
                2'd2:    altFf  <= bus.wData & IMPL;
                default: dataFf <= dataFf;
            endcase
        end
    end

    assign bus.dataOut = dataFf;
    assign bus.dirOut  = dirFf;
    assign bus.altOut  = altFf;

endmodule

`default_nettype wire

// ### core/gpn_ports.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - first port five bits; mode bit 1 drives data register bit onto pin
// - second port bits 3, 4, 5, each input or output by mode bit
// - third port bits 0 to 3, each input or output by mode bit
// - peripheral output drives pin only when mode and alternate bits are 1
// - mode 0 with alternate 1 enables the pin pull-up
// - first port bits 0 to 3 in alternate output drive 0
// - third port bits 0 and 1 in alternate output drive 0
// - every reset cause clears all registers, pins become inputs
// - mode 0 read returns live pin level
// - mode 1, alternate 0 read returns data register bit
// - first port alternate read: bits 0-3 zero, bit 7 hold-acknowledge
// - second port alternate read: serial clock, serial data, then zero
// - third port alternate read: zeros, clock output, oscillator output
// - read-modify-write reads read-back values, writes data register
// - unimplemented bit positions read zero
// - peripheral inputs see the same synchronised pin signal
module gpn_ports
    import gpn_pkg::*;
(
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_b,
    // reset causes besides the reset pin
    input  wire logic          break_instruction,
    input  wire logic          watchdog_overflow,
    input  wire logic          opcode_trap,
    // ahb-lite slave
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    // peripheral outputs routed to pins
    input  wire logic          bus_hold_ack_out,
    input  wire logic          serial_clock_line,
    input  wire logic          serial_data_out,
    input  wire logic          system_clock_out,
    input  wire logic          oscillator_out,
    // peripheral inputs taken from pins
    output logic               ext_irq_in_a,
    output logic               ext_irq_in_b,
    output logic               ext_irq_in_c,
    output logic               ext_irq_in_d,
    output logic               serial_clock_in,
    output logic               serial_data_in,
    output logic               wait_in,
    output logic               hold_in,
    // pins
    input  wire logic [7:0]    p9PinIn,
    output logic [7:0]         p9PinOut,
    output logic [7:0]         p9PinOe,
    output logic [7:0]         p9PullUp,
    input  wire logic [7:0]    p10PinIn,
    output logic [7:0]         p10PinOut,
    output logic [7:0]         p10PinOe,
    output logic [7:0]         p10PullUp,
    input  wire logic [7:0]    p11PinIn,
    output logic [7:0]         p11PinOut,
    output logic [7:0]         p11PinOe,
    output logic [7:0]         p11PullUp
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    // selected read-back value of one port
    function automatic logic [7:0] readBack(
        input logic [7:0] pin,
        input logic [7:0] data,
        input logic [7:0] dir,
        input logic [7:0] alt,
        input logic [7:0] altVal,
        input logic [7:0] impl
    );
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (!dir[i]) begin
                r[i] = pin[i];
            end else if (!alt[i]) begin
                r[i] = data[i];
            end else begin
                r[i] = altVal[i];
            end
        end
        return r & impl;
    endfunction

    // pin output value
    function automatic logic [7:0] pinValue(
        input logic [7:0] data,
        input logic [7:0] alt,
        input logic [7:0] altVal
    );
        return (alt & altVal) | (~alt & data);
    endfunction

    // ----------------------------------------------------------------
    // combined reset
    // ----------------------------------------------------------------
    logic       softRst_ff;
    logic       bankRst_b;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            softRst_ff <= 1'b0;
        end else begin
            softRst_ff <= break_instruction | watchdog_overflow | opcode_trap;
        end
    end

    assign bankRst_b = rst_b & ~softRst_ff;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [7:0] p9Meta_ff;
    logic [7:0] p9Sync_ff;
    logic [7:0] p10Meta_ff;
    logic [7:0] p10Sync_ff;
    logic [7:0] p11Meta_ff;
    logic [7:0] p11Sync_ff;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            p9Meta_ff  <= 8'h00;
            p9Sync_ff  <= 8'h00;
            p10Meta_ff <= 8'h00;
            p10Sync_ff <= 8'h00;
            p11Meta_ff <= 8'h00;
            p11Sync_ff <= 8'h00;
        end else begin
            p9Meta_ff  <= p9PinIn;
            p9Sync_ff  <= p9Meta_ff;
            p10Meta_ff <= p10PinIn;
            p10Sync_ff <= p10Meta_ff;
            p11Meta_ff <= p11PinIn;
            p11Sync_ff <= p11Meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // ahb-lite address phase
    // ----------------------------------------------------------------
    logic       dpValid_ff;
    logic       dpWrite_ff;
    logic [7:0] dpAddr_ff;
    logic       addrPhase;

    assign addrPhase = hsel & hready & htrans[1];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dpValid_ff <= 1'b0;
            dpWrite_ff <= 1'b0;
            dpAddr_ff  <= 8'h00;
        end else begin
            dpValid_ff <= addrPhase;
            dpWrite_ff <= addrPhase & hwrite;
            dpAddr_ff  <= addrPhase ? haddr[7:0] : dpAddr_ff;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ----------------------------------------------------------------
    // register banks
    // ----------------------------------------------------------------
    gpn_bank_if b9 ();
    gpn_bank_if b10 ();
    gpn_bank_if b11 ();

    gpn_port_bank #(.IMPL(P9_IMPL)) u_bank9 (
        .mclk  (mclk),
        .rst_b (bankRst_b),
        .bus   (b9.bank)
    );
    gpn_port_bank #(.IMPL(P10_IMPL)) u_bank10 (
        .mclk  (mclk),
        .rst_b (bankRst_b),
        .bus   (b10.bank)
    );
    gpn_port_bank #(.IMPL(P11_IMPL)) u_bank11 (
        .mclk  (mclk),
        .rst_b (bankRst_b),
        .bus   (b11.bank)
    );

    // ----------------------------------------------------------------
    // alternate output values per port
    // ----------------------------------------------------------------
    logic [7:0] p9AltVal;
    logic [7:0] p10AltVal;
    logic [7:0] p11AltVal;
    logic [7:0] p9Rb;
    logic [7:0] p10Rb;
    logic [7:0] p11Rb;

    assign p9AltVal  = {bus_hold_ack_out, 3'b000, 4'h0} & ~P9_ZERO_ALT;
    assign p10AltVal = {2'b00, 1'b0, serial_data_out, serial_clock_line, 3'b000}
                       & ~P10_ZERO_ALT;
    assign p11AltVal = {4'h0, oscillator_out, system_clock_out, 2'b00}
                       & ~P11_ZERO_ALT;

    assign p9Rb  = readBack(p9Sync_ff, b9.dataOut, b9.dirOut, b9.altOut,
                            p9AltVal, P9_IMPL);
    assign p10Rb = readBack(p10Sync_ff, b10.dataOut, b10.dirOut, b10.altOut,
                            p10AltVal, P10_IMPL);
    assign p11Rb = readBack(p11Sync_ff, b11.dataOut, b11.dirOut, b11.altOut,
                            p11AltVal, P11_IMPL);

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    logic [1:0] wrSel;
    logic [1:0] wrPort;
    logic       wrHit;

    always_comb begin
        wrSel  = 2'd0;
        wrPort = 2'd0;
        wrHit  = 1'b1;
        unique case (dpAddr_ff)
            P9_DATA_OFS:  begin wrPort = 2'd0; wrSel = 2'd0; end
            P9_DIR_OFS:   begin wrPort = 2'd0; wrSel = 2'd1; end
            P9_ALT_OFS:   begin wrPort = 2'd0; wrSel = 2'd2; end
            P10_DATA_OFS: begin wrPort = 2'd1; wrSel = 2'd0; end
            P10_DIR_OFS:  begin wrPort = 2'd1; wrSel = 2'd1; end
            P10_ALT_OFS:  begin wrPort = 2'd1; wrSel = 2'd2; end
            P11_DATA_OFS: begin wrPort = 2'd2; wrSel = 2'd0; end
            P11_DIR_OFS:  begin wrPort = 2'd2; wrSel = 2'd1; end
            P11_ALT_OFS:  begin wrPort = 2'd2; wrSel = 2'd2; end
            default:      wrHit = 1'b0;
        endcase
    end

    assign b9.wrEn   = dpWrite_ff & wrHit & (wrPort == 2'd0);
    assign b10.wrEn  = dpWrite_ff & wrHit & (wrPort == 2'd1);
    assign b11.wrEn  = dpWrite_ff & wrHit & (wrPort == 2'd2);
    assign b9.sel    = wrSel;
    assign b10.sel   = wrSel;
    assign b11.sel   = wrSel;
    assign b9.wData  = hwdata[7:0];
    assign b10.wData = hwdata[7:0];
    assign b11.wData = hwdata[7:0];

    // ----------------------------------------------------------------
    // read data, taken from the same read-back used by rmw
    // ----------------------------------------------------------------
    logic [7:0] rdByte;

    always_comb begin
        unique case (dpAddr_ff)
            P9_DATA_OFS:  rdByte = p9Rb;
            P9_DIR_OFS:   rdByte = b9.dirOut;
            P9_ALT_OFS:   rdByte = b9.altOut;
            P10_DATA_OFS: rdByte = p10Rb;
            P10_DIR_OFS:  rdByte = b10.dirOut;
            P10_ALT_OFS:  rdByte = b10.altOut;
            P11_DATA_OFS: rdByte = p11Rb;
            P11_DIR_OFS:  rdByte = b11.dirOut;
            P11_ALT_OFS:  rdByte = b11.altOut;
            default:      rdByte = 8'h00;
        endcase
    end

    assign hrdata = {24'h000000, rdByte};

    // ----------------------------------------------------------------
    // pin drive and pull-ups
    // ----------------------------------------------------------------
    // first port drive
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            p9PinOut  <= 8'h00;
            p9PinOe   <= 8'h00;
            p9PullUp  <= 8'h00;
        end else begin
            p9PinOut  <= pinValue(b9.dataOut, b9.altOut, p9AltVal) & P9_IMPL;
            p9PinOe   <= b9.dirOut & P9_IMPL;
            p9PullUp  <= ~b9.dirOut & b9.altOut & P9_IMPL;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            p10PinOut <= 8'h00;
            p10PinOe  <= 8'h00;
            p10PullUp <= 8'h00;
        end else begin
            p10PinOut <= pinValue(b10.dataOut, b10.altOut, p10AltVal) & P10_IMPL;
            p10PinOe  <= b10.dirOut & P10_IMPL;
            p10PullUp <= ~b10.dirOut & b10.altOut & P10_IMPL;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            p11PinOut <= 8'h00;
            p11PinOe  <= 8'h00;
            p11PullUp <= 8'h00;
        end else begin
            p11PinOut <= pinValue(b11.dataOut, b11.altOut, p11AltVal) & P11_IMPL;
            p11PinOe  <= b11.dirOut & P11_IMPL;
            p11PullUp <= ~b11.dirOut & b11.altOut & P11_IMPL;
        end
    end

    // ----------------------------------------------------------------
    // peripheral inputs
    // ----------------------------------------------------------------
    // shared synchronised pin
    assign ext_irq_in_a    = p9Sync_ff[0];
    assign ext_irq_in_b    = p9Sync_ff[1];
    assign ext_irq_in_c    = p9Sync_ff[2];
    assign ext_irq_in_d    = p9Sync_ff[3];
    assign serial_clock_in = p10Sync_ff[3];
    assign serial_data_in  = p10Sync_ff[5];
    assign wait_in         = p11Sync_ff[0];
    assign hold_in         = p11Sync_ff[1];

endmodule

`default_nettype wire

// ### sim/gpn_ports_props.sv
`timescale 1ns/1ps
`default_nettype none

module gpn_ports_props
    import gpn_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        rst_b,
    // bus side
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        break_instruction,
    // pin side
    input wire logic [7:0]  p9PinIn,
    input wire logic [7:0]  p9PinOut,
    input wire logic [7:0]  p9PinOe,
    input wire logic [7:0]  p9PullUp,
    input wire logic [7:0]  p10PinOe,
    input wire logic [7:0]  p10PullUp,
    input wire logic [7:0]  p11PinIn,
    input wire logic [7:0]  p11PinOe,
    input wire logic [7:0]  p11PullUp,
    input wire logic        ext_irq_in_a,
    input wire logic        wait_in
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_okay;
        hrdata[31:8] == 24'h0 && hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus response or upper read bits wrong");

    property p_unmapped;
        hsel && hready && htrans[1] && !hwrite && haddr[7:0] > 8'h20 |=> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_impl;
        ((p9PinOe | p9PullUp | p9PinOut) & ~P9_IMPL) == 8'h0 &&
        ((p10PinOe | p10PullUp) & ~P10_IMPL) == 8'h0 &&
        ((p11PinOe | p11PullUp) & ~P11_IMPL) == 8'h0;
    endproperty
    a_impl: assert property (p_impl)
        else $error("activity on a missing pin");

    property p_pull;
        (p9PinOe & p9PullUp) == 8'h0 && (p10PinOe & p10PullUp) == 8'h0 &&
        (p11PinOe & p11PullUp) == 8'h0;
    endproperty
    a_pull: assert property (p_pull)
        else $error("pull-up on a driven pin");

    property p_soft_clear;
        break_instruction |-> ##[2:3] (p9PinOe | p10PinOe | p11PinOe) == 8'h0;
    endproperty
    a_soft_clear: assert property (p_soft_clear)
        else $error("pins still driven after soft reset");

    property p_reset_idle;
        $rose(rst_b) |-> (p9PinOe | p10PinOe | p11PinOe | p9PullUp | p10PullUp | p11PullUp) == 8'h0;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("pins active after reset");

    property p_irq_feed;
        $stable(p9PinIn[0]) [*3] |-> ext_irq_in_a == p9PinIn[0];
    endproperty
    a_irq_feed: assert property (p_irq_feed)
        else $error("interrupt input does not follow pin");

    property p_wait_feed;
        $stable(p11PinIn[0]) [*3] |-> wait_in == p11PinIn[0];
    endproperty
    a_wait_feed: assert property (p_wait_feed)
        else $error("wait input does not follow pin");

    c_write: cover property (hsel && htrans[1] && hwrite);
    c_soft: cover property (break_instruction);
    c_pull: cover property (p9PullUp != 8'h0);
endmodule

bind gpn_ports gpn_ports_props u_props (
    .mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
    .hrdata, .break_instruction, .p9PinIn, .p9PinOut, .p9PinOe, .p9PullUp,
    .p10PinOe, .p10PullUp, .p11PinIn, .p11PinOe, .p11PullUp, .ext_irq_in_a, .wait_in
);

`default_nettype wire

// ### sim/gpn_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

// pins of one port: device driver, outside source, pull-up, else floating
module gpn_pin_model (
    // clock
    input  wire logic       mclk,
    // device side
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOe,
    input  wire logic [7:0] pullUp,
    // outside source
    input  wire logic [7:0] extDrv,
    input  wire logic [7:0] extEn,
    // resolved level
    output logic [7:0]      pinLvl
);
    logic [7:0] floatPat = 8'h55;

    // a floating pin changes every cycle so no stale level reads back
    always @(posedge mclk) begin
        floatPat <= ~floatPat;
    end

    // a pulled-up input with no source reads high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pinOe[i]) begin
                pinLvl[i] = pinOut[i];
            end else if (extEn[i]) begin
                pinLvl[i] = extDrv[i];
            end else if (pullUp[i]) begin
                pinLvl[i] = 1'b1;
            end else begin
                pinLvl[i] = floatPat[i];
            end
        end
    end
endmodule

`default_nettype wire

// ### sim/gpn_ports_tb.sv
`timescale 1ns/1ps
`default_nettype none

module gpn_ports_tb;
    logic        mclk;
    logic        rst_b;
    logic [2:0]  softRst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [4:0]  periph;
    wire  [7:0]  feed;
    logic [7:0]  pOut [3];
    logic [7:0]  pOe [3];
    logic [7:0]  pPu [3];
    logic [7:0]  pLvl [3];
    logic [7:0]  extDrv [3];
    logic [7:0]  extEn [3];
    logic [7:0]  impl [3];
    logic [7:0]  pat;
    logic [31:0] rdv;
    int          n_fail;
    int          cmp_count;

    gpn_ports dut (
        .mclk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hreadyout, .hresp, .hrdata,
        .break_instruction (softRst[0]), .watchdog_overflow (softRst[1]),
        .opcode_trap (softRst[2]), .hsize (3'b010), .hready (hreadyout),
        .bus_hold_ack_out (periph[0]), .serial_clock_line (periph[1]),
        .serial_data_out (periph[2]), .system_clock_out (periph[3]),
        .oscillator_out (periph[4]),
        .ext_irq_in_a (feed[0]), .ext_irq_in_b (feed[1]), .ext_irq_in_c (feed[2]),
        .ext_irq_in_d (feed[3]), .serial_clock_in (feed[4]), .serial_data_in (feed[5]),
        .wait_in (feed[6]), .hold_in (feed[7]),
        .p9PinIn (pLvl[0]), .p9PinOut (pOut[0]), .p9PinOe (pOe[0]), .p9PullUp (pPu[0]),
        .p10PinIn (pLvl[1]), .p10PinOut (pOut[1]), .p10PinOe (pOe[1]), .p10PullUp (pPu[1]),
        .p11PinIn (pLvl[2]), .p11PinOut (pOut[2]), .p11PinOe (pOe[2]), .p11PullUp (pPu[2])
    );

    for (genvar i = 0; i < 3; i++) begin : g_pin
        gpn_pin_model u_pin (
            .mclk, .pinOut (pOut[i]), .pinOe (pOe[i]), .pullUp (pPu[i]),
            .extDrv (extDrv[i]), .extEn (extEn[i]), .pinLvl (pLvl[i])
        );
    end

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // one ahb-lite single transfer, read data taken at the data-phase edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] rd);
        int   n;
        logic rdy;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        hsel <= 1'b1;
        for (int ph = 0; ph < 2; ph++) begin
            n = 0;
            // values read here are those sampled at this rising edge
            do begin
                @(posedge mclk);
                rdy = hreadyout;
                rd = hrdata;
                n++;
            end while (rdy !== 1'b1 && n < 20);
            if (rdy !== 1'b1) begin
                $display("unexpected hready wait expected 1 seen %b", rdy);
                n_fail++;
                conclude();
            end
            // data phase only once; a following call may raise htrans at this edge
            if (ph == 0) begin
                htrans <= 2'b00;
                hwdata <= {24'h0, d};
            end
        end
    endtask

    task automatic settle;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    function automatic logic [7:0] ofs(int p, int r);
        return 8'(p * 12 + r * 4);
    endfunction

    task automatic cfg(int p, logic [7:0] dir, logic [7:0] alt);
        logic [31:0] dummy;
        xfer(1'b1, ofs(p, 1), dir, dummy);
        xfer(1'b1, ofs(p, 2), alt, dummy);
        settle();
    endtask

    // read-back of alternate outputs per port, peripheral lines as given
    function automatic logic [7:0] altExp(int p, logic [4:0] v);
        case (p)
            0: return {v[0], 7'h00};
            1: return {2'b00, 1'b0, v[2], v[1], 3'b000};
            default: return {4'h0, v[4], v[3], 2'b00};
        endcase
    endfunction

    initial begin
        rst_b = 1'b0;
        softRst = 3'b000;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        periph = 5'h00;
        impl = '{8'h8f, 8'h38, 8'h0f};
        extDrv = '{8'h00, 8'h00, 8'h00};
        extEn = '{8'h00, 8'h00, 8'h00};
        n_fail = 0;
        cmp_count = 0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        for (int p = 0; p < 3; p++) begin
            for (int r = 1; r < 3; r++) begin
                xfer(1'b0, ofs(p, r), 8'h00, rdv);
                chk("ctrl reset", 32'h0, rdv);
            end
            chk("oe reset", 32'h0, pOe[p]);
        end
        xfer(1'b1, 8'h24, 8'hff, rdv);
        xfer(1'b0, 8'h24, 8'h00, rdv);
        chk("unmapped", 32'h0, rdv);
        // ---------------------------------------------------------
        // inputs, pull-ups, outputs, alternate outputs
        // ---------------------------------------------------------
        for (int k = 0; k < 2; k++) begin
            pat = k ? 8'h5a : 8'ha5;
            for (int p = 0; p < 3; p++) begin
                extDrv[p] <= pat;
                extEn[p] <= 8'hff;
            end
            settle();
            chk("feed", {pat[1], pat[0], pat[5], pat[3], pat[3:0]}, feed);
            for (int p = 0; p < 3; p++) begin
                xfer(1'b0, ofs(p, 0), 8'h00, rdv);
                chk("pin read", pat & impl[p], rdv);
            end
        end
        for (int p = 0; p < 3; p++) begin
            cfg(p, 8'h00, 8'hff);
            chk("pull", impl[p], pPu[p]);
            xfer(1'b0, ofs(p, 0), 8'h00, rdv);
            chk("pin read alt", pat & impl[p], rdv);
            extEn[p] <= 8'h00;
            settle();
            xfer(1'b0, ofs(p, 0), 8'h00, rdv);
            chk("pulled read", impl[p], rdv);
            xfer(1'b1, ofs(p, 0), 8'h5a, rdv);
            cfg(p, 8'hff, 8'h00);
            chk("oe", impl[p], pOe[p]);
            chk("out", 8'h5a & impl[p], pOut[p]);
            xfer(1'b0, ofs(p, 0), 8'h00, rdv);
            chk("data read", 8'h5a & impl[p], rdv);
            // all-ones data so fixed-zero alternate bits show a fault
            xfer(1'b1, ofs(p, 0), 8'hff, rdv);
            for (int v = 0; v < 2; v++) begin
                periph <= v ? 5'h1f : 5'h00;
                cfg(p, 8'hff, 8'hff);
                chk("alt out", altExp(p, periph), pOut[p]);
                xfer(1'b0, ofs(p, 0), 8'h00, rdv);
                chk("alt read", altExp(p, periph), rdv);
            end
            xfer(1'b1, ofs(p, 0), 8'h00, rdv);
            cfg(p, 8'hff, 8'h00);
            chk("stored", 32'h0, pOut[p]);
        end
        cfg(0, 8'h0f, 8'h00);
        extDrv[0] <= 8'h80;
        extEn[0] <= 8'h80;
        settle();
        xfer(1'b0, 8'h00, 8'h00, rdv);
        chk("rmw read", 32'h80, rdv);
        xfer(1'b1, 8'h00, rdv[7:0] | 8'h01, rdv);
        extEn[0] <= 8'h00;
        cfg(0, 8'h8f, 8'h00);
        chk("rmw out", 32'h81, pOut[0]);
        // ---------------------------------------------------------
        // soft reset causes
        // ---------------------------------------------------------
        for (int c = 0; c < 3; c++) begin
            xfer(1'b1, ofs(2, 0), 8'hff, rdv);
            cfg(2, 8'hff, 8'h00);
            softRst <= 3'(1 << c);
            @(posedge mclk);
            softRst <= 3'b000;
            settle();
            xfer(1'b0, ofs(2, 1), 8'h00, rdv);
            chk("soft dir", 32'h0, rdv);
            xfer(1'b1, ofs(2, 1), 8'hff, rdv);
            settle();
            chk("soft data", 32'h0, pOut[2]);
        end
        conclude();
    end
endmodule

`default_nettype wire
